// ===== common/tms_params.svh
`ifndef TMS_PARAMS_SVH
`define TMS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TMS_OFF_CORE_CONFIG 8'h00
`define TMS_OFF_HIT_COUNT 8'h01
`define TMS_OFF_TIMEOUT 8'h02
`define TMS_OFF_MASK_DELAY_LOW 8'h03
`define TMS_OFF_MASK_DELAY_HIGH 8'h04
`define TMS_OFF_MASK_CONTROL 8'h08
`define TMS_OFF_REARM_CONTROL 8'h0a
`define TMS_OFF_STATUS 8'h26
`define TMS_OFF_RX_ENABLES 8'h2e

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TMS_CC_HIT_EN1 0
`define TMS_CC_HIT_EN2 1
`define TMS_CC_MERGE 3
`define TMS_MC_STEP_LO 2
`define TMS_MC_SRC 4
`define TMS_MC_ENA 5
`define TMS_RC_CS_OPT 0
`define TMS_RC_AUTO 1
`define TMS_RX_BIAS 0
`define TMS_RX_START_DIFF 2
`define TMS_RX_CH1_DIFF 3
`define TMS_RX_CH2_DIFF 4
`define TMS_RX_START_CMOS 5
`define TMS_RX_CH1_CMOS 6
`define TMS_RX_CH2_CMOS 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TMS_RST_CORE_CONFIG 8'h04
`define TMS_RST_ZERO 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TMS_CLK_PERIOD_NS 8
`define TMS_REF_PERIOD_NS 8
`define TMS_WARMUP_PERIODS 20
`define TMS_WARMUP_CYC \
    ((`TMS_WARMUP_PERIODS * `TMS_REF_PERIOD_NS + `TMS_CLK_PERIOD_NS - 1) / `TMS_CLK_PERIOD_NS)
`define TMS_STEP_DIV 1024
`define TMS_STEP_CODE0 1
`define TMS_STEP_CODE1 2
`define TMS_STEP_CODE2 5
`define TMS_STEP_CODE3 10
`define TMS_BUF_DEPTH 8

`endif

// ===== common/tms_pkg.sv
package tms_pkg;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TMS_IDLE,
        TMS_SYNC,
        TMS_WARMUP,
        TMS_WAIT_START,
        TMS_MEASURE,
        TMS_DONE
    } tms_state_t;

endpackage

// ===== core/tms_pin_sync.sv
module tms_pin_sync (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    output logic level_o
);

    logic ff1;
    logic ff2;
    logic ff3;

    // Only the second stage reads the first; a change counts once the
    // second and third stages agree.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ff1 <= 1'b0;
            ff2 <= 1'b0;
            ff3 <= 1'b0;
        end else begin
            ff1 <= pin_i;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            level_o <= 1'b0;
        end else if (ff2 == ff3) begin
            level_o <= ff3;
        end
    end

endmodule // tms_pin_sync

// ===== core/tms_hit_channel.sv
`include "tms_params.svh"

module tms_hit_channel (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clear_i,
    input wire logic rise_i,
    input wire logic fall_i,
    input wire logic [23:0] now_i,
    input wire logic [3:0] limit_i,
    input wire logic pop_i,
    output logic [3:0] count_o,
    output logic full_o,
    output logic empty_o,
    output logic [23:0] tof_o,
    output logic [23:0] width_o
);

    logic [23:0] tof_mem [`TMS_BUF_DEPTH];
    logic [23:0] wid_mem [`TMS_BUF_DEPTH];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic pend_valid;
    logic [23:0] pend_tof;
    logic do_wr;
    logic do_pop;

    assign full_o = (count_o >= limit_i);
    assign empty_o = (count_o == 4'h0);
    assign do_wr = fall_i && pend_valid && !full_o;
    assign do_pop = pop_i && !empty_o;
    assign tof_o = tof_mem[rd_ptr];
    assign width_o = wid_mem[rd_ptr];

    // A rising edge opens a hit; its falling edge closes it and stores
    // both the flight time and the width as one entry.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || clear_i) begin
            pend_valid <= 1'b0;
            pend_tof <= 24'h0;
        end else if (rise_i && !pend_valid && !full_o) begin
            pend_valid <= 1'b1;
            pend_tof <= now_i;
        end else if (fall_i) begin
            pend_valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (do_wr) begin
            tof_mem[wr_ptr] <= pend_tof;
            wid_mem[wr_ptr] <= now_i - pend_tof;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || clear_i) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count_o <= 4'h0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            count_o <= count_o + {3'h0, do_wr} - {3'h0, do_pop};
        end
    end

endmodule // tms_hit_channel

// ===== core/tms_sequencer.sv
// Notes on behaviour
// - Core arms and accepts hits only after the initialise command arrives.
// - Each stop hit captures rising and falling edge: flight time and width.
// - Completion flagged when expected hits arrive or timeout expires, whichever first; a timeout with no stored hit leaves irq_n_o high.
// - Every cycle ends needing a re-arm; controller triggers or enables automatic one.
// - Chip-select option re-arms on select rising edge once empty and interrupt high.
// - Re-initialise command clears core and buffers anytime after initialise, then waits for hits.
// - Automatic option re-arms on select rising edge even with unread data.
// - Positive pulse on re-arm pin re-initialises core and buffers at any time after initialise.
// - Only first start rising edge after arming opens measurement and mask window.
// - Stops active high, both edges timed against accepted start edge.
// - Stop hits accepted only with software enables bits 1, 0; bit 2 is 1.
// - Merge mode feeds both channels alternately from the stop 1 pin.
// - External mask pin high suppresses both stop channels; low allows them.
// - Mask enable bit 5 masks when set; bit 4 selects internal or pin.
// - Internal mask starts at valid start and releases after the set interval.
// - Mask delay is 12 bits, low byte and high nibble, 0 to 4095 steps.
// - Mask step code selects 1, 2, 5 or 10 of 1024 reference periods.
// - After initialise: sync, enable core, wait 20 periods, then enable start.
// - Each channel delivers 24-bit flight time and 24-bit width results.
// - Interrupt output is active low and stays low until results are read or a re-arm clears the buffers.
// - 8-bit timeout from start counts reference periods; zero disables it.

`include "tms_params.svh"

module tms_sequencer
    import tms_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic cmd_init_i,
    input wire logic cmd_reinit_i,
    input wire logic start_pin_i,
    input wire logic stop1_pin_i,
    input wire logic stop2_pin_i,
    input wire logic mask_pin_i,
    input wire logic rearm_pin_i,
    input wire logic chip_select_n_i,
    input wire logic rd_pop_i,
    input wire logic rd_ch_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_n_o,
    output logic buffers_empty_flag_o,
    output logic armed_o,
    output logic [23:0] flight_time_result_o,
    output logic [23:0] width_result_o
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] core_config;
    logic [7:0] hit_count_config;
    logic [7:0] timeout_config;
    logic [7:0] mask_delay_low;
    logic [7:0] mask_delay_high;
    logic [7:0] mask_control;
    logic [7:0] rearm_control;
    logic [7:0] input_receiver_enables;

    tms_state_t state;
    logic [4:0] warm_cnt;
    logic [23:0] now;
    logic [7:0] tmo_cnt;
    logic [15:0] mask_cnt;
    logic merge_sel;
    logic [5:0] pin_lvl;
    logic [5:0] pin_prev;
    logic [5:0] pin_rise;
    logic [5:0] pin_fall;
    logic [3:0] ch_count [2];
    logic [1:0] ch_full;
    logic [1:0] ch_empty;
    logic [23:0] ch_tof [2];
    logic [23:0] ch_wid [2];
    logic [1:0] ch_rise;
    logic [1:0] ch_fall;
    logic [1:0] ch_pop;
    logic [1:0] ch_en;
    logic clear;
    logic rearm;
    logic start_ok;
    logic stops_masked;
    logic hits_done;
    logic timed_out;
    logic all_empty;
    logic cs_rise;
    logic [11:0] mask_delay;
    logic [3:0] step_num;
    logic [15:0] mask_cycles;

    // ------------------------------------------------------------------
    // Pin synchronisers and edges
    // ------------------------------------------------------------------
    logic [5:0] pins_raw;
    assign pins_raw = {~chip_select_n_i, rearm_pin_i, mask_pin_i,
                       stop2_pin_i, stop1_pin_i, start_pin_i};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            tms_pin_sync u_sync (
                .ref_clk_i(ref_clk_i),
                .nrst_i(nrst_i),
                .pin_i(pins_raw[gi]),
                .level_o(pin_lvl[gi])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pin_prev <= 6'h00;
        end else begin
            pin_prev <= pin_lvl;
        end
    end

    assign pin_rise = pin_lvl & ~pin_prev;
    assign pin_fall = ~pin_lvl & pin_prev;
    assign cs_rise = pin_fall[5];

    // ------------------------------------------------------------------
    // Register writes and reads
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            core_config <= `TMS_RST_CORE_CONFIG;
            hit_count_config <= `TMS_RST_ZERO;
            timeout_config <= `TMS_RST_ZERO;
            mask_delay_low <= `TMS_RST_ZERO;
            mask_delay_high <= `TMS_RST_ZERO;
            mask_control <= `TMS_RST_ZERO;
            rearm_control <= `TMS_RST_ZERO;
            input_receiver_enables <= `TMS_RST_ZERO;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `TMS_OFF_CORE_CONFIG: core_config <= reg_wdata_i;
                `TMS_OFF_HIT_COUNT: hit_count_config <= reg_wdata_i;
                `TMS_OFF_TIMEOUT: timeout_config <= reg_wdata_i;
                `TMS_OFF_MASK_DELAY_LOW: mask_delay_low <= reg_wdata_i;
                `TMS_OFF_MASK_DELAY_HIGH: mask_delay_high <= reg_wdata_i;
                `TMS_OFF_MASK_CONTROL: mask_control <= reg_wdata_i;
                `TMS_OFF_REARM_CONTROL: rearm_control <= reg_wdata_i;
                `TMS_OFF_RX_ENABLES: input_receiver_enables <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `TMS_OFF_CORE_CONFIG: reg_rdata_o <= core_config;
                `TMS_OFF_HIT_COUNT: reg_rdata_o <= hit_count_config;
                `TMS_OFF_TIMEOUT: reg_rdata_o <= timeout_config;
                `TMS_OFF_MASK_DELAY_LOW: reg_rdata_o <= mask_delay_low;
                `TMS_OFF_MASK_DELAY_HIGH: reg_rdata_o <= mask_delay_high;
                `TMS_OFF_MASK_CONTROL: reg_rdata_o <= mask_control;
                `TMS_OFF_REARM_CONTROL: reg_rdata_o <= rearm_control;
                `TMS_OFF_RX_ENABLES: reg_rdata_o <= input_receiver_enables;
                `TMS_OFF_STATUS: reg_rdata_o <= {ch_count[1], ch_count[0]};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Re-arm sources
    // ------------------------------------------------------------------
    // The select option only re-arms a finished cycle once every result
    // has been drained; the automatic option does not wait for that.
    always_comb begin
        rearm = 1'b0;
        if (state != TMS_IDLE) begin
            if (cmd_reinit_i) begin
                rearm = 1'b1;
            end
            if (pin_rise[4]) begin
                rearm = 1'b1;
            end
        end
        if (state == TMS_DONE && cs_rise) begin
            if (rearm_control[`TMS_RC_AUTO]) begin
                rearm = 1'b1;
            end
            if (rearm_control[`TMS_RC_CS_OPT] && all_empty && irq_n_o) begin
                rearm = 1'b1;
            end
        end
    end

    assign clear = cmd_init_i || rearm;
    assign all_empty = &ch_empty;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Start is usable only with a receiver enabled; a differential start
    // also needs the bias current.
    assign start_ok = (input_receiver_enables[`TMS_RX_START_CMOS] ||
                       (input_receiver_enables[`TMS_RX_START_DIFF] &&
                        input_receiver_enables[`TMS_RX_BIAS]));

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state <= TMS_IDLE;
            warm_cnt <= 5'h0;
        end else if (cmd_init_i) begin
            state <= TMS_SYNC;
            warm_cnt <= 5'h0;
        end else if (rearm) begin
            state <= TMS_WAIT_START;
        end else begin
            unique case (state)
                TMS_IDLE: ;
                TMS_SYNC: begin
                    state <= TMS_WARMUP;
                end
                TMS_WARMUP: begin
                    warm_cnt <= warm_cnt + 5'h1;
                    if (warm_cnt == 5'(`TMS_WARMUP_CYC - 1)) begin
                        state <= TMS_WAIT_START;
                    end
                end
                TMS_WAIT_START: begin
                    if (pin_rise[0] && start_ok) begin
                        state <= TMS_MEASURE;
                    end
                end
                TMS_MEASURE: begin
                    if (hits_done || timed_out) begin
                        state <= TMS_DONE;
                    end
                end
                TMS_DONE: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Time base and timeout
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || state != TMS_MEASURE) begin
            now <= 24'h1;
            tmo_cnt <= 8'h0;
        end else begin
            if (now != 24'hffffff) begin
                now <= now + 24'h1;
            end
            if (tmo_cnt != 8'hff) begin
                tmo_cnt <= tmo_cnt + 8'h1;
            end
        end
    end

    // The counter starts with the start edge, so the window is exact to
    // within one reference period.
    assign timed_out = (timeout_config != 8'h00) &&
                       (tmo_cnt + 8'h1 >= timeout_config);

    // ------------------------------------------------------------------
    // Stop mask
    // ------------------------------------------------------------------
    assign mask_delay = {mask_delay_high[3:0], mask_delay_low};

    always_comb begin
        unique case (mask_control[`TMS_MC_STEP_LO +: 2])
            2'h0: step_num = 4'(`TMS_STEP_CODE0);
            2'h1: step_num = 4'(`TMS_STEP_CODE1);
            2'h2: step_num = 4'(`TMS_STEP_CODE2);
            2'h3: step_num = 4'(`TMS_STEP_CODE3);
        endcase
    end

    // A least time, so the fraction of a period rounds up.
    assign mask_cycles = 16'((32'(mask_delay) * 32'(step_num) + `TMS_STEP_DIV - 1)
                             / `TMS_STEP_DIV);

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || clear) begin
            mask_cnt <= 16'h0;
        end else if (state == TMS_WAIT_START && pin_rise[0] && start_ok) begin
            mask_cnt <= mask_cycles;
        end else if (mask_cnt != 16'h0) begin
            mask_cnt <= mask_cnt - 16'h1;
        end
    end

    always_comb begin
        stops_masked = 1'b0;
        if (mask_control[`TMS_MC_ENA]) begin
            if (mask_control[`TMS_MC_SRC]) begin
                stops_masked = pin_lvl[3];
            end else begin
                stops_masked = (mask_cnt != 16'h0);
            end
        end
    end

    // ------------------------------------------------------------------
    // Stop gating and channel routing
    // ------------------------------------------------------------------
    // In merge mode both channels follow the stop 1 pin and its enables.
    always_comb begin
        ch_en[0] = core_config[`TMS_CC_HIT_EN1] &&
                   (input_receiver_enables[`TMS_RX_CH1_CMOS] ||
                    input_receiver_enables[`TMS_RX_CH1_DIFF]);
        ch_en[1] = core_config[`TMS_CC_HIT_EN2] &&
                   (input_receiver_enables[`TMS_RX_CH2_CMOS] ||
                    input_receiver_enables[`TMS_RX_CH2_DIFF]);
        if (core_config[`TMS_CC_MERGE]) begin
            ch_en[1] = ch_en[0];
        end
    end

    always_comb begin
        ch_rise = 2'b00;
        ch_fall = 2'b00;
        if (state == TMS_MEASURE && !stops_masked) begin
            if (core_config[`TMS_CC_MERGE]) begin
                ch_rise[merge_sel] = pin_rise[1] && ch_en[merge_sel];
                ch_fall[merge_sel] = pin_fall[1] && ch_en[merge_sel];
            end else begin
                ch_rise = pin_rise[2:1] & ch_en;
                ch_fall = pin_fall[2:1] & ch_en;
            end
        end
    end

    // The selector moves on the falling edge so each pulse keeps both
    // of its edges in one channel.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || clear) begin
            merge_sel <= 1'b0;
        end else if (|ch_fall && core_config[`TMS_CC_MERGE]) begin
            merge_sel <= ~merge_sel;
        end
    end

    assign hits_done = (|ch_en) && (&(ch_full | ~ch_en));
    assign ch_pop[0] = rd_pop_i && !rd_ch_i;
    assign ch_pop[1] = rd_pop_i && rd_ch_i;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            tms_hit_channel u_ch (
                .ref_clk_i(ref_clk_i),
                .nrst_i(nrst_i),
                .clear_i(clear),
                .rise_i(ch_rise[gi]),
                .fall_i(ch_fall[gi]),
                .now_i(now),
                .limit_i({1'b0, hit_count_config[3*gi +: 3]} + 4'h1),
                .pop_i(ch_pop[gi]),
                .count_o(ch_count[gi]),
                .full_o(ch_full[gi]),
                .empty_o(ch_empty[gi]),
                .tof_o(ch_tof[gi]),
                .width_o(ch_wid[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            irq_n_o <= 1'b1;
            buffers_empty_flag_o <= 1'b1;
            armed_o <= 1'b0;
            flight_time_result_o <= 24'h0;
            width_result_o <= 24'h0;
        end else begin
            irq_n_o <= !(state == TMS_DONE && !all_empty && !clear);
            buffers_empty_flag_o <= all_empty;
            armed_o <= (state == TMS_WAIT_START) || (state == TMS_MEASURE);
            flight_time_result_o <= ch_tof[rd_ch_i];
            width_result_o <= ch_wid[rd_ch_i];
        end
    end

endmodule // tms_sequencer

// ===== tb/tms_sequencer_assertions.sv
module tms_sequencer_assertions (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_init_i,
    input wire logic cmd_reinit_i,
    input wire logic rearm_pin_i,
    input wire logic irq_n_o,
    input wire logic buffers_empty_flag_o,
    input wire logic armed_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Re-arm sources are ignored before the first initialise command.
    logic inited;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            inited <= 1'b0;
        end else if (cmd_init_i) begin
            inited <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    chk_init_disarms: assert property (cmd_init_i |-> ##2 !armed_o [*8])
        else $error("armed during warmup");
    chk_warmup_len: assert property (cmd_init_i |-> ##22 !armed_o ##1 armed_o)
        else $error("warmup length wrong");
    chk_done_idle: assert property (!irq_n_o |-> !armed_o)
        else $error("armed while completion pending");
    chk_init_clears: assert property (cmd_init_i || cmd_reinit_i |-> ##[1:3] buffers_empty_flag_o)
        else $error("buffers not cleared");
    chk_reinit_arms: assert property (cmd_reinit_i && inited && !cmd_init_i |-> ##[1:3] armed_o)
        else $error("reinit did not arm");
    chk_pin_rearm: assert property ($rose(rearm_pin_i) && inited && !cmd_init_i ##1 rearm_pin_i
        |-> ##[0:7] armed_o)
        else $error("rearm pin did not arm");
    chk_idle_keeps: assert property (!armed_o && buffers_empty_flag_o |=> buffers_empty_flag_o)
        else $error("hit stored while not armed");
    chk_irq_release: assert property ($rose(irq_n_o) |-> ##[0:1] (buffers_empty_flag_o || armed_o))
        else $error("completion released with data left");
endmodule // tms_sequencer_assertions

bind tms_sequencer tms_sequencer_assertions chk (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cmd_init_i(cmd_init_i),
    .cmd_reinit_i(cmd_reinit_i),
    .rearm_pin_i(rearm_pin_i),
    .irq_n_o(irq_n_o),
    .buffers_empty_flag_o(buffers_empty_flag_o),
    .armed_o(armed_o)
);

// ===== tb/tms_far_end.sv
module tms_far_end (
    input wire logic ref_clk_i,
    output logic start_o,
    output logic stop1_o,
    output logic stop2_o,
    output logic cs_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        start_o = 1'b0;
        stop1_o = 1'b0;
        stop2_o = 1'b0;
        cs_n_o = 1'b1;
    end
    // Stop pulses are active high; each one is a rise followed by a fall.
    task automatic hit(input logic ch, input int w);
        @(posedge ref_clk_i);
        if (ch) stop2_o <= 1'b1; else stop1_o <= 1'b1;
        repeat (w) @(posedge ref_clk_i);
        if (ch) stop2_o <= 1'b0; else stop1_o <= 1'b0;
    endtask
    task automatic fire_start();
        @(posedge ref_clk_i);
        start_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        start_o <= 1'b0;
    endtask
    task automatic cs_pulse();
        @(posedge ref_clk_i);
        cs_n_o <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
    endtask
endmodule // tms_far_end

// ===== tb/tms_sequencer_bench.sv
module tms_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [3:0] strb = 4'h0;
    logic mask_pin_i = 1'b0;
    logic rd_ch_i = 1'b0;
    logic start, stop1, stop2, cs_n, irq_n_o, empty, armed_o;
    logic [7:0] reg_rdata_o;
    logic [23:0] tof, width;
    int n_errors = 0;
    int n_checks = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    tms_far_end far (.ref_clk_i(ref_clk_i), .start_o(start), .stop1_o(stop1),
        .stop2_o(stop2), .cs_n_o(cs_n));
    tms_sequencer dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .cmd_init_i(strb[0]), .cmd_reinit_i(strb[1]), .rearm_pin_i(strb[2]),
        .rd_pop_i(strb[3]), .start_pin_i(start), .stop1_pin_i(stop1),
        .stop2_pin_i(stop2), .mask_pin_i(mask_pin_i), .chip_select_n_i(cs_n),
        .rd_ch_i(rd_ch_i), .reg_rdata_o(reg_rdata_o), .irq_n_o(irq_n_o),
        .buffers_empty_flag_o(empty), .armed_o(armed_o),
        .flight_time_result_o(tof), .width_result_o(width));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk({16'h0, reg_rdata_o}, {16'h0, e});
    endtask
    // Pins pass a synchroniser that drops pulses shorter than two cycles.
    task automatic strobe(input int k, input int n = 1);
        @(posedge ref_clk_i);
        strb[k] <= 1'b1;
        repeat (n) @(posedge ref_clk_i);
        strb[k] <= 1'b0;
    endtask
    task automatic look(input logic c, input logic [23:0] t, input logic [23:0] w);
        @(posedge ref_clk_i);
        rd_ch_i <= c;
        repeat (2) @(posedge ref_clk_i);
        #1 chk(tof, t);
        chk(width, w);
    endtask
    // Bounded wait, so a stuck sequencer ends in a mismatch, not a hang.
    task automatic wait_armed(input logic v);
        for (int i = 0; i < 40 && armed_o !== v; i++) @(posedge ref_clk_i) #1;
        #1 chk({23'h0, armed_o}, {23'h0, v});
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rd(8'h00, 8'h04);
        rd(8'h08, 8'h00);
        rd(8'h05, 8'h00);
        wr(8'h03, 8'hff);
        wr(8'h04, 8'h0f);
        rd(8'h03, 8'hff);
        rd(8'h04, 8'h0f);
        wr(8'h2e, 8'he0);
        wr(8'h00, 8'h07);
        far.hit(1'b0, 3);
        repeat (6) @(posedge ref_clk_i);
        chk({23'h0, empty}, 24'h1);
        strobe(0);
        repeat (21) @(posedge ref_clk_i);
        #1 chk({23'h0, armed_o}, 24'h0);
        wait_armed(1'b1);
        far.fire_start();
        fork
            far.hit(1'b0, 3);
            far.hit(1'b1, 5);
        join
        for (int i = 0; i < 40 && irq_n_o !== 1'b0; i++) @(posedge ref_clk_i) #1;
        #1 chk({23'h0, irq_n_o}, 24'h0);
        look(1'b0, 24'd5, 24'd3);
        look(1'b1, 24'd5, 24'd5);
        strobe(3);
        rd_ch_i <= 1'b0;
        strobe(3);
        repeat (3) @(posedge ref_clk_i);
        #1 chk({22'h0, irq_n_o, empty}, 24'h3);
        wr(8'h0a, 8'h01);
        far.cs_pulse();
        wait_armed(1'b1);
        wr(8'h02, 8'h0a);
        far.fire_start();
        #1 chk({23'h0, armed_o}, 24'h1);
        wait_armed(1'b0);
        strobe(2, 3);
        wait_armed(1'b1);
        wr(8'h08, 8'h30);
        mask_pin_i <= 1'b1;
        far.fire_start();
        far.hit(1'b0, 3);
        wait_armed(1'b0);
        rd(8'h26, 8'h00);
        strobe(1);
        wait_armed(1'b1);
        wr(8'h02, 8'h00);
        wr(8'h00, 8'h0d);
        wr(8'h08, 8'h2c);
        wr(8'h0a, 8'h02);
        far.fire_start();
        far.hit(1'b0, 2);
        repeat (40) @(posedge ref_clk_i);
        far.hit(1'b0, 3);
        repeat (3) @(posedge ref_clk_i);
        far.hit(1'b0, 4);
        for (int i = 0; i < 40 && irq_n_o !== 1'b0; i++) @(posedge ref_clk_i) #1;
        #1 chk({23'h0, irq_n_o}, 24'h0);
        look(1'b0, 24'd48, 24'd3);
        rd(8'h26, 8'h11);
        look(1'b1, 24'd55, 24'd4);
        far.cs_pulse();
        wait_armed(1'b1);
        chk({23'h0, empty}, 24'h1);
        print_verdict();
    end
endmodule // tms_sequencer_bench
